// ---- logic/dwct_cal.sv ----
`default_nettype none
module dwct_cal (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // link to the register side
  dwct_cal_if.cal cal
);
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_ALIGN = 2'h1,
    CAL_RUN = 2'h3
  } dwct_cal_e;

  typedef struct packed {
    dwct_cal_e state;
    logic [15:0] left;
    logic [31:0] fast;
    logic [31:0] result;
    logic done;
  } dwct_cal_s;

  dwct_cal_s r;
  dwct_cal_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.state)
      CAL_IDLE:
      begin
        if (cal.req)
        begin
          next_r.left = cal.ticks;
          next_r.fast = '0;
          next_r.state = CAL_ALIGN;
        end
      end
      // start on a slow edge so the window spans whole periods
      CAL_ALIGN:
      begin
        if (cal.slow_tick)
          next_r.state = (r.left == '0) ? CAL_IDLE : CAL_RUN;
        if (cal.slow_tick && r.left == '0)
        begin
          next_r.result = '0;
          next_r.done = 1'b1;
        end
      end
      CAL_RUN:
      begin
        if (cal.periph_tick)
          next_r.fast = r.fast + 32'h00000001;
        if (cal.slow_tick)
        begin
          next_r.left = r.left - 16'h0001;
          if (r.left == 16'h0001)
          begin
            next_r.result = next_r.fast;
            next_r.done = 1'b1;
            next_r.state = CAL_IDLE;
          end
        end
      end
      default:
      begin
        next_r.state = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '{state: CAL_IDLE, default: '0};
    else if (ce)
      r <= next_r;
  end

  assign cal.busy = (r.state != CAL_IDLE);
  assign cal.done = r.done;
  assign cal.result = r.result;
endmodule
`default_nettype wire

// ---- logic/dwct_cal_if.sv ----
`default_nettype none
interface dwct_cal_if;
  logic slow_tick;
  logic periph_tick;
  logic req;
  logic [15:0] ticks;
  logic busy;
  logic done;
  logic [31:0] result;
  modport top (output slow_tick, output periph_tick, output req, output ticks,
    input busy, input done, input result);
  modport cal (input slow_tick, input periph_tick, input req, input ticks,
    output busy, output done, output result);
endinterface
`default_nettype wire

// ---- logic/dwct_counter.sv ----
`default_nettype none
module dwct_counter #(
  parameter int WIDTH = dwct_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] load,
  // state
  output logic [WIDTH-1:0] count,
  output logic active,
  output logic fire
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic active;
    logic fire;
  } dwct_cnt_s;

  dwct_cnt_s r;
  dwct_cnt_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.fire = 1'b0;
    if (stop)
    begin
      next_r.active = 1'b0;
    end
    else if (start)
    begin
      next_r.count = load;
      next_r.active = 1'b1;
    end
    else if (r.active && tick)
    begin
      if (r.count == '0)
      begin
        next_r.count = {WIDTH{1'b1}};
        next_r.fire = 1'b1;
      end
      else
      begin
        next_r.count = r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else if (ce)
      r <= next_r;
  end

  assign count = r.count;
  assign active = r.active;
  assign fire = r.fire;
endmodule
`default_nettype wire

// ---- logic/dwct_pkg.sv ----
`default_nettype none
package dwct_pkg;
  // ==========================================================
  // counter geometry
  localparam int CNT_W = 41;
  localparam int LO_W = 32;
  localparam int HI_W = 9;
  localparam int NUM_TIMERS = 2;
  localparam int CAL_W = 16;
  localparam int RES_W = 32;

  // ==========================================================
  // clock figures
  localparam int SLOW_HZ = 32000;
  localparam int PERIPH_HZ = 16000000;
  localparam int NOMINAL_RATIO = PERIPH_HZ / SLOW_HZ;
  localparam logic [15:0] BASIC_CAL_TICKS = 16'h0014;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IEN = 8'h04;
  localparam logic [7:0] OFS_START_LO = 8'h08;
  localparam logic [7:0] OFS_START_HI = 8'h0C;
  localparam logic [7:0] OFS_CNT0_LO = 8'h10;
  localparam logic [7:0] OFS_CNT0_HI = 8'h14;
  localparam logic [7:0] OFS_CNT1_LO = 8'h18;
  localparam logic [7:0] OFS_CNT1_HI = 8'h1C;
  localparam logic [7:0] OFS_ACTIVE = 8'h20;
  localparam logic [7:0] OFS_FIRED = 8'h24;
  localparam logic [7:0] OFS_CAL_TICKS = 8'h28;
  localparam logic [7:0] OFS_CAL_RESULT = 8'h2C;
  localparam logic [7:0] OFS_INT_STATUS = 8'h30;
  localparam logic [7:0] OFS_INT_MASK = 8'h34;

  // ==========================================================
  // field positions
  localparam int CTRL_START_POS = 0;
  localparam int CTRL_STOP_POS = 2;
  localparam int CTRL_CAL_BASIC_POS = 4;
  localparam int CTRL_CAL_ENH_POS = 5;
  localparam int IEN_SEL_POS = 8;
  localparam int CAL_BUSY_POS = 31;
  localparam int INT_CAL_POS = 2;
  localparam int INT_W = 3;

  // ==========================================================
  // values after reset and at rollover
  localparam logic [CNT_W-1:0] ROLL_VALUE = 41'h1FFFFFFFFFF;
  localparam logic [CAL_W-1:0] CAL_TICKS_RESET = 16'h0014;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;
endpackage
`default_nettype wire

// ---- logic/dwct_top.sv ----
// Behaviour
// - on start load count, decrement per slow tick; at zero fire, reload ones
// - start count is in slow-clock periods; seconds equal count over 32000
// - stopping a timer keeps its stored interrupt-enable setting
// - the live 41-bit count reads without disturbing the counter
// - full-width start enables the upper nine bits as well as the low 32
// - active bitmap with one bit per timer; both may run together
// - active bit survives rollover and clears only on stop
// - fired bit latched per timer at zero pass; reading the bitmap clears all
// - basic calibration uses timer 0 over twenty slow periods
// - basic result is 10000 at exact 32kHz; larger means slower
// - enhanced calibration counts peripheral ticks over a 16-bit slow count
// - expiry wakes only if the interrupt was enabled at start
// - writing a running timer's interrupt enable stops that timer
// - an explicit stop raises no interrupt
//
// Our own choices: the register addresses and the Wishbone register port.
`default_nettype none
module dwct_top (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock pins
  input wire logic slow_clk_pin,
  input wire logic periph_clk_pin,
  // events
  output logic irq,
  output logic wake
);
  localparam int NT = dwct_pkg::NUM_TIMERS;

  typedef struct packed {
    logic [2:0] slow_sync;
    logic slow_lvl;
    logic slow_tick;
    logic [2:0] per_sync;
    logic per_lvl;
    logic per_tick;
    logic [NT-1:0] ien;
    logic [NT-1:0] armed;
    logic [31:0] start_lo;
    logic [8:0] start_hi;
    logic [8:0] snap0;
    logic [8:0] snap1;
    logic [NT-1:0] fired;
    logic [NT-1:0] start;
    logic [NT-1:0] stop;
    logic cal_req;
    logic [15:0] cal_len;
    logic [15:0] cal_ticks;
    logic [2:0] int_st;
    logic [2:0] int_mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic wake;
  } dwct_top_s;

  dwct_top_s r;
  dwct_top_s next_r;
  logic [dwct_pkg::CNT_W-1:0] cnt [NT];
  logic [NT-1:0] active;
  logic [NT-1:0] fire;

  dwct_cal_if cal_link ();

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
    input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        res[8*b +: 8] = wr[8*b +: 8];
    return res;
  endfunction

  function automatic logic stable_level(input logic [2:0] sync, input logic lvl);
    stable_level = (sync[1] == sync[2]) ? sync[2] : lvl;
  endfunction

  // ==========================================================
  // timers
  for (genvar i = 0; i < NT; i++)
  begin : g_timer
    dwct_counter #(.WIDTH(dwct_pkg::CNT_W)) u_cnt (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .tick(r.slow_tick),
      .start(r.start[i]),
      .stop(r.stop[i]),
      .load({r.start_hi, r.start_lo}),
      .count(cnt[i]),
      .active(active[i]),
      .fire(fire[i])
    );
  end

  // ==========================================================
  // calibration
  assign cal_link.slow_tick = r.slow_tick;
  assign cal_link.periph_tick = r.per_tick;
  assign cal_link.req = r.cal_req;
  assign cal_link.ticks = r.cal_len;

  dwct_cal u_cal (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cal(cal_link.cal)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic acc;
    logic [31:0] wv;
    acc = wb_cyc_i & wb_stb_i & ~r.ack;
    wv = '0;
    next_r = r;
    next_r.ack = acc;
    next_r.dat = '0;
    next_r.start = '0;
    next_r.stop = '0;
    next_r.cal_req = 1'b0;
    // three-stage pin synchronisers, a change counts once stages two and three agree
    next_r.slow_sync = {r.slow_sync[1:0], slow_clk_pin};
    next_r.slow_lvl = stable_level(r.slow_sync, r.slow_lvl);
    next_r.slow_tick = next_r.slow_lvl & ~r.slow_lvl;
    next_r.per_sync = {r.per_sync[1:0], periph_clk_pin};
    next_r.per_lvl = stable_level(r.per_sync, r.per_lvl);
    next_r.per_tick = next_r.per_lvl & ~r.per_lvl;
    if (acc && !wb_we_i)
    begin
      case (wb_adr_i)
        dwct_pkg::OFS_IEN: next_r.dat = {30'h0, r.ien};
        dwct_pkg::OFS_START_LO: next_r.dat = r.start_lo;
        dwct_pkg::OFS_START_HI: next_r.dat = {23'h0, r.start_hi};
        dwct_pkg::OFS_CNT0_LO:
        begin
          next_r.dat = cnt[0][31:0];
          next_r.snap0 = cnt[0][40:32];
        end
        dwct_pkg::OFS_CNT0_HI: next_r.dat = {23'h0, r.snap0};
        dwct_pkg::OFS_CNT1_LO:
        begin
          next_r.dat = cnt[1][31:0];
          next_r.snap1 = cnt[1][40:32];
        end
        dwct_pkg::OFS_CNT1_HI: next_r.dat = {23'h0, r.snap1};
        dwct_pkg::OFS_ACTIVE: next_r.dat = {30'h0, active};
        dwct_pkg::OFS_FIRED:
        begin
          next_r.dat = {30'h0, r.fired};
          next_r.fired = '0;
        end
        dwct_pkg::OFS_CAL_TICKS: next_r.dat = {16'h0, r.cal_ticks};
        dwct_pkg::OFS_CAL_RESULT:
        begin
          next_r.dat = cal_link.result;
          next_r.dat[dwct_pkg::CAL_BUSY_POS] = cal_link.busy;
        end
        dwct_pkg::OFS_INT_STATUS: next_r.dat = {29'h0, r.int_st};
        dwct_pkg::OFS_INT_MASK: next_r.dat = {29'h0, r.int_mask};
        default: next_r.dat = '0;
      endcase
    end
    if (acc && wb_we_i)
    begin
      case (wb_adr_i)
        dwct_pkg::OFS_CTRL:
        begin
          wv = merge(32'h0, wb_dat_i, wb_sel_i);
          for (int i = 0; i < NT; i++)
          begin
            if (wv[dwct_pkg::CTRL_STOP_POS + i])
              next_r.stop[i] = 1'b1;
            else if (wv[dwct_pkg::CTRL_START_POS + i] && !(i == 0 && cal_link.busy))
            begin
              next_r.start[i] = 1'b1;
              next_r.armed[i] = r.ien[i];
            end
          end
          if (!cal_link.busy && !active[0])
          begin
            if (wv[dwct_pkg::CTRL_CAL_BASIC_POS])
            begin
              next_r.cal_req = 1'b1;
              next_r.cal_len = dwct_pkg::BASIC_CAL_TICKS;
            end
            else if (wv[dwct_pkg::CTRL_CAL_ENH_POS])
            begin
              next_r.cal_req = 1'b1;
              next_r.cal_len = r.cal_ticks;
            end
          end
        end
        dwct_pkg::OFS_IEN:
        begin
          wv = merge(32'h0, wb_dat_i, wb_sel_i);
          for (int i = 0; i < NT; i++)
          begin
            if (wv[dwct_pkg::IEN_SEL_POS + i])
            begin
              next_r.ien[i] = wv[i];
              next_r.stop[i] = active[i];
            end
          end
        end
        dwct_pkg::OFS_START_LO: next_r.start_lo = merge(r.start_lo, wb_dat_i, wb_sel_i);
        dwct_pkg::OFS_START_HI:
        begin
          wv = merge({23'h0, r.start_hi}, wb_dat_i, wb_sel_i);
          next_r.start_hi = wv[8:0];
        end
        dwct_pkg::OFS_CAL_TICKS:
        begin
          wv = merge({16'h0, r.cal_ticks}, wb_dat_i, wb_sel_i);
          next_r.cal_ticks = wv[15:0];
        end
        dwct_pkg::OFS_INT_STATUS:
        begin
          wv = merge(32'h0, wb_dat_i, wb_sel_i);
          next_r.int_st = r.int_st & ~wv[2:0];
        end
        dwct_pkg::OFS_INT_MASK:
        begin
          wv = merge({29'h0, r.int_mask}, wb_dat_i, wb_sel_i);
          next_r.int_mask = wv[2:0];
        end
        default: next_r.ack = acc;
      endcase
    end
    // events set after clears so a simultaneous set wins
    next_r.fired = next_r.fired | fire;
    next_r.int_st[NT-1:0] = next_r.int_st[NT-1:0] | (fire & r.armed);
    next_r.int_st[dwct_pkg::INT_CAL_POS] = next_r.int_st[dwct_pkg::INT_CAL_POS] | cal_link.done;
    next_r.irq = |(next_r.int_st & next_r.int_mask);
    next_r.wake = |(fire & r.armed);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      r <= '{cal_ticks: dwct_pkg::CAL_TICKS_RESET, int_mask: dwct_pkg::INT_MASK_RESET,
        default: '0};
    else if (ce)
      r <= next_r;
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign irq = r.irq;
  assign wake = r.wake;
endmodule
`default_nettype wire

// ---- sim/dwct_asserts.sv ----
`default_nettype none
module dwct_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins and events
  input wire logic slow_clk_pin,
  input wire logic irq,
  input wire logic wake
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // cycles since the slow pin rose
  logic slow_q;
  logic [5:0] since_rise;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slow_q <= 1'b0;
      since_rise <= 6'h3F;
    end
    else
    begin
      slow_q <= slow_clk_pin;
      if (slow_clk_pin && !slow_q)
        since_rise <= 6'h00;
      else if (since_rise != 6'h3F)
        since_rise <= since_rise + 6'h01;
    end
  end
  // ========
  // checks
  a_ack_one_cycle: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack held");
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
    else $error("ack late");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  a_unmapped_reads_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
    && (wb_adr_i == dwct_pkg::OFS_CTRL || wb_adr_i > dwct_pkg::OFS_INT_MASK)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_wake_one_pulse: assert property (wake |=> !wake) else $error("wake held");
  a_wake_after_tick: assert property (wake |-> since_rise inside {[6'h01:6'h14]})
    else $error("wake not after slow tick");
  a_irq_fall_write: assert property ($fell(irq) |->
    (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i)) else $error("irq fell alone");
endmodule
bind dwct_top dwct_asserts chk_u (.clk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .slow_clk_pin, .irq, .wake);
`default_nettype wire

// ---- sim/tb_dual_wake_countdown_timer.sv ----
`default_nettype none
module tb_dual_wake_countdown_timer;
  timeunit 1ns;
  timeprecision 100ps;
  // ========
  // signals
  logic clk, rst, ce, cyc, stb, we, slow, periph, irq, wake, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rd;
  int n_fail = 0;
  int samples_checked = 0;
  int n_wake = 0;
  int slow_half = 500;
  dwct_top dut_u (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .slow_clk_pin(slow), .periph_clk_pin(periph), .irq(irq), .wake(wake));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    periph = 1'b0;
    #13;
    // matches the slow pin only after t_calib sets slow_half, giving the nominal ratio 500
    forever #50 periph = ~periph;
  end
  initial slow = 1'b0;
  always #(slow_half) slow = ~slow;
  always @(posedge clk) if (wake === 1'b1) n_wake <= n_wake + 1;
  // ========
  // shared tasks
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 16);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 16)
    begin
      n_fail++;
      $display("Error %0t: no ack", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check({9'h0, rd}, {9'h0, exp});
  endtask
  task automatic cal_run(input logic [31:0] ctl, input int exp);
    int n;
    wr(dwct_pkg::OFS_CTRL, ctl);
    repeat (8) @(posedge clk);
    n = 0;
    do
    begin
      xfer(1'b0, dwct_pkg::OFS_CAL_RESULT, 32'h0);
      n++;
    end
    while (rd[31] !== 1'b0 && n < 20000);
    if (n >= 20000)
    begin
      n_fail++;
      print_verdict();
    end
    check(rd >= exp - 1 && rd <= exp + 1, 1'b1);
  endtask
  // ========
  // scenarios
  task automatic t_reset_vals();
    rd_chk(dwct_pkg::OFS_IEN, 32'h0);
    rd_chk(dwct_pkg::OFS_CAL_TICKS, 32'h14);
    rd_chk(dwct_pkg::OFS_INT_MASK, 32'h0);
    rd_chk(dwct_pkg::OFS_ACTIVE, 32'h0);
    rd_chk(dwct_pkg::OFS_FIRED, 32'h0);
    rd_chk(8'h3C, 32'h0);
    rd_chk(dwct_pkg::OFS_CTRL, 32'h0);
  endtask
  task automatic t_fire_armed();
    int n;
    wr(dwct_pkg::OFS_IEN, 32'h101);
    wr(dwct_pkg::OFS_INT_MASK, 32'h1);
    wr(dwct_pkg::OFS_START_LO, 32'h2);
    wr(dwct_pkg::OFS_START_HI, 32'h0);
    wr(dwct_pkg::OFS_CTRL, 32'h1);
    n = 0;
    while (wake !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check(n >= 80 && n <= 132, 1'b1);
    if (n >= 400)
      print_verdict();
    rd_chk(dwct_pkg::OFS_FIRED, 32'h1);
    rd_chk(dwct_pkg::OFS_FIRED, 32'h0);
    rd_chk(dwct_pkg::OFS_ACTIVE, 32'h1);
    rd_chk(dwct_pkg::OFS_INT_STATUS, 32'h1);
    check(irq, 1'b1);
    xfer(1'b0, dwct_pkg::OFS_CNT0_LO, 32'h0);
    check(rd[31:1], 31'h7FFFFFFF);
    rd_chk(dwct_pkg::OFS_CNT0_HI, 32'h1FF);
    wr(dwct_pkg::OFS_INT_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
  endtask
  task automatic t_two_timers();
    int w;
    wr(dwct_pkg::OFS_IEN, 32'h202);
    wr(dwct_pkg::OFS_START_HI, 32'h1);
    wr(dwct_pkg::OFS_START_LO, 32'h10);
    wr(dwct_pkg::OFS_CTRL, 32'h2);
    rd_chk(dwct_pkg::OFS_ACTIVE, 32'h3);
    xfer(1'b0, dwct_pkg::OFS_CNT1_LO, 32'h0);
    rd_chk(dwct_pkg::OFS_CNT1_HI, 32'h1);
    w = n_wake;
    wr(dwct_pkg::OFS_CTRL, 32'h8);
    rd_chk(dwct_pkg::OFS_ACTIVE, 32'h1);
    rd_chk(dwct_pkg::OFS_IEN, 32'h3);
    wr(dwct_pkg::OFS_IEN, 32'h100);
    rd_chk(dwct_pkg::OFS_ACTIVE, 32'h0);
    wr(dwct_pkg::OFS_START_HI, 32'h0);
    wr(dwct_pkg::OFS_START_LO, 32'h2);
    wr(dwct_pkg::OFS_CTRL, 32'h1);
    repeat (200) @(posedge clk);
    check(n_wake - w, 0);
    rd_chk(dwct_pkg::OFS_FIRED, 32'h1);
    rd_chk(dwct_pkg::OFS_INT_STATUS, 32'h0);
    wr(dwct_pkg::OFS_CTRL, 32'h4);
    rd_chk(dwct_pkg::OFS_ACTIVE, 32'h0);
  endtask
  task automatic t_calib();
    slow_half = 25000;
    wr(dwct_pkg::OFS_INT_MASK, 32'h0);
    wr(dwct_pkg::OFS_CAL_TICKS, 32'h2);
    cal_run(32'h20, 1000);
    rd_chk(dwct_pkg::OFS_INT_STATUS, 32'h4);
    check(irq, 1'b0);
    cal_run(32'h10, 10000);
  endtask
  // ========
  // main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat_w = 32'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_fire_armed();
    t_two_timers();
    t_calib();
    print_verdict();
  end
endmodule
`default_nettype wire
